// file: pkg/monitor_regs_defines.vh
// Register map, field layout, reset values and timing constants of the monitor
`ifndef MONITOR_REGS_DEFINES_VH
`define MONITOR_REGS_DEFINES_VH

// Pointer addresses
`define PTR_CONFIGURATION      8'h00
`define PTR_CURRENT_RESULT     8'h01
`define PTR_BUS_VOLTAGE_RESULT 8'h02
`define PTR_POWER_RESULT       8'h03
`define PTR_ALERT_MASK_ENABLE  8'h06
`define PTR_ALERT_LIMIT        8'h07
`define PTR_MAKER_IDENTITY     8'hFE
`define PTR_DIE_IDENTITY       8'hFF

// Reset values
`define RST_CONFIGURATION      16'h6127
`define RST_RESULT             16'h0000
`define RST_ALERT_MASK_ENABLE  16'h0000
`define RST_ALERT_LIMIT        16'h0000

// Configuration fields
`define CFG_SW_RESET_BIT       15
`define CFG_FIXED_PATTERN      3'h6
`define CFG_RW_MASK            16'h0FFF
`define CFG_AVG_HI             11
`define CFG_AVG_LO             9
`define CFG_VCT_HI             8
`define CFG_VCT_LO             6
`define CFG_ICT_HI             5
`define CFG_ICT_LO             3
`define CFG_MODE_HI            2
`define CFG_MODE_LO            0

// Alert mask/enable fields
`define MSK_RW_MASK            16'hFC03
`define MSK_FUNC_FLAG_BIT      4
`define MSK_CONV_READY_BIT     3
`define MSK_LATCH_BIT          0

// Serial bus
`define ALERT_RESPONSE_ADDR    7'h0C

// Clock rate and conversion times
`define CLK_MHZ                125
`define CT0_NS                 140000
`define CT1_NS                 204000
`define CT2_NS                 332000
`define CT3_NS                 588000
`define CT4_NS                 1100000
`define CT5_NS                 2116000
`define CT6_NS                 4156000
`define CT7_NS                 8244000

`endif

// file: hw/conv_sequencer.v
// Conversion timebase: averaged current and voltage conversion sequence
`timescale 1ns/100ps
`include "monitor_regs_defines.vh"
module conv_sequencer #(
  parameter [23:0] CT0_CYC = `CT0_NS * `CLK_MHZ / 1000,
  parameter [23:0] CT1_CYC = `CT1_NS * `CLK_MHZ / 1000,
  parameter [23:0] CT2_CYC = `CT2_NS * `CLK_MHZ / 1000,
  parameter [23:0] CT3_CYC = `CT3_NS * `CLK_MHZ / 1000,
  parameter [23:0] CT4_CYC = `CT4_NS * `CLK_MHZ / 1000,
  parameter [23:0] CT5_CYC = `CT5_NS * `CLK_MHZ / 1000,
  parameter [23:0] CT6_CYC = `CT6_NS * `CLK_MHZ / 1000,
  parameter [23:0] CT7_CYC = `CT7_NS * `CLK_MHZ / 1000
) (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // Control
  input  wire        halt,
  input  wire        restart,
  input  wire [2:0]  avgSel,
  input  wire [2:0]  voltTimeSel,
  input  wire [2:0]  currTimeSel,
  input  wire [2:0]  modeSel,
  // Result strobe
  output reg         convDone_q
);

  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_CURR = 2'h1;
  localparam [1:0] S_VOLT = 2'h2;

  reg [1:0]  state_q;
  reg [23:0] cnt_q;
  reg [10:0] samples_q;

  // Conversion time code to cycles
  function [23:0] ctCycles;
    input [2:0] code;
    begin
      case (code)
        3'h0: ctCycles = CT0_CYC;
        3'h1: ctCycles = CT1_CYC;
        3'h2: ctCycles = CT2_CYC;
        3'h3: ctCycles = CT3_CYC;
        3'h4: ctCycles = CT4_CYC;
        3'h5: ctCycles = CT5_CYC;
        3'h6: ctCycles = CT6_CYC;
        default: ctCycles = CT7_CYC;
      endcase
    end
  endfunction

  // Averaging code to sample count minus one
  function [10:0] avgLast;
    input [2:0] code;
    begin
      case (code)
        3'h0: avgLast = 11'h000;
        3'h1: avgLast = 11'h003;
        3'h2: avgLast = 11'h00F;
        3'h3: avgLast = 11'h03F;
        3'h4: avgLast = 11'h07F;
        3'h5: avgLast = 11'h0FF;
        3'h6: avgLast = 11'h1FF;
        default: avgLast = 11'h3FF;
      endcase
    end
  endfunction

  // Phase sequencer
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q    <= S_IDLE;
      cnt_q      <= 24'h000000;
      samples_q  <= 11'h000;
      convDone_q <= 1'b0;
    end else begin
      convDone_q <= 1'b0;
      if (halt) begin
        state_q <= S_IDLE;
      end else if (restart) begin
        samples_q <= avgLast(avgSel);
        if (modeSel[0]) begin
          state_q <= S_CURR;
          cnt_q   <= ctCycles(currTimeSel);
        end else if (modeSel[1]) begin
          state_q <= S_VOLT;
          cnt_q   <= ctCycles(voltTimeSel);
        end else begin
          state_q <= S_IDLE;
        end
      end else begin
        case (state_q)
          S_IDLE: begin
            cnt_q <= 24'h000000;
          end
          S_CURR, S_VOLT: begin
            if (cnt_q > 24'h000001) begin
              cnt_q <= cnt_q - 24'h000001;
            end else if (state_q == S_CURR && modeSel[1]) begin
              state_q <= S_VOLT;
              cnt_q   <= ctCycles(voltTimeSel);
            end else begin
              if (samples_q == 11'h000) begin
                convDone_q <= 1'b1;
                samples_q  <= avgLast(avgSel);
              end else begin
                samples_q <= samples_q - 11'h001;
              end
              if (samples_q != 11'h000 || modeSel[2]) begin
                state_q <= modeSel[0] ? S_CURR : S_VOLT;
                cnt_q   <= modeSel[0] ? ctCycles(currTimeSel) : ctCycles(voltTimeSel);
              end else begin
                state_q <= S_IDLE;
              end
            end
          end
          default: state_q <= S_IDLE;
        endcase
      end
    end
  end

endmodule // conv_sequencer

// file: hw/monitor_register_bank.v
// Serial register bank of the power monitor with alert response
// Function
// - Answer alert response address only while alert latching is enabled.
// - Pending alert: acknowledge alert response, then send own address.
// - Concurrent responders arbitrate; lowest address wins.
// - Arbitration loser stops, no further drive, keeps alert low.
// - Winner sends its address, then releases the alert line.
// - Alert release leaves internal flags set; host clears them.
// - Current, voltage, power results read-only at 01h..03h, reset zero.
// - Configuration at 00h, read/write, powers up 6127h.
// - Mask/enable at 06h, resets zero, holds alert setup and ready flag.
// - Alert limit at 07h, read/write, resets zero.
// - Fixed maker and die identity at FEh and FFh.
// - Reading configuration disturbs nothing.
// - Configuration write halts conversion while the write is underway.
// - Completed configuration write starts a fresh conversion.
// - Configuration bit 15 written one triggers full reset.
// - Soft reset restores all register defaults; reset bit self-clears.
// - Bits 11..9 select averaging 1 to 1024 samples.
// - Bits 8..6 select voltage conversion time.
// - Bits 5..3 select current conversion time.
// - Bits 2..0 select power-down, triggered or continuous measuring.
`timescale 1ns/100ps
`include "monitor_regs_defines.vh"
module monitor_register_bank #(
  parameter [6:0]  SLAVE_ADDR = 7'h40,
  parameter [15:0] MAKER_ID   = 16'hA5A5, // Arbitrary value
  parameter [15:0] DIE_ID     = 16'h1234  // Arbitrary value
) (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // Serial bus pins
  input  wire        sclIn,
  input  wire        sdaIn,
  output reg         sdaOut_q,
  output reg         sdaOe_q,
  // Alert pin
  output reg         alertOut_q,
  output reg         alertOe_q,
  // Measurement datapath
  input  wire [15:0] currentIn,
  input  wire [15:0] voltageIn,
  input  wire [15:0] powerIn,
  input  wire        alertCond
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_ACK  = 3'h2;
  localparam [2:0] ST_RX   = 3'h3;
  localparam [2:0] ST_TX   = 3'h4;
  localparam [2:0] ST_MACK = 3'h5;
  localparam [15:0] CFG_RESET = `RST_CONFIGURATION;

  // Pin synchronisers and edge history
  reg        sclS1_q, sclS2_q, sclS3_q;
  reg        sdaS1_q, sdaS2_q, sdaS3_q;
  // Serial engine
  reg [2:0]  state_q;
  reg [3:0]  bitCnt_q;
  reg [7:0]  shift_q;
  reg        ackOn_q;
  reg        isRead_q;
  reg        isAra_q;
  reg        txHi_q;
  reg [1:0]  byteIdx_q;
  reg [7:0]  ptr_q;
  reg [7:0]  msb_q;
  // Register file and control
  reg [11:0] cfg_q;
  reg [15:0] mask_q;
  reg [15:0] limit_q;
  reg [15:0] current_q, voltage_q, power_q;
  reg        funcFlag_q, readyFlag_q, released_q;
  reg        swRst_q, halt_q, restart_q;
  reg        wrStb_q, maskRd_q, araWin_q;
  reg [15:0] wrData_q;
  reg [15:0] rdWord;
  reg [7:0]  txByte;

  wire       convDone;
  wire       sclRise  = sclS2_q & ~sclS3_q;
  wire       sclFall  = ~sclS2_q & sclS3_q;
  wire       busStart = sclS2_q & sclS3_q & sdaS3_q & ~sdaS2_q;
  wire       busStop  = sclS2_q & sclS3_q & ~sdaS3_q & sdaS2_q;
  wire [7:0] rxByte   = {shift_q[6:0], sdaS2_q};
  wire [15:0] cfgView = {1'b0, `CFG_FIXED_PATTERN, cfg_q};
  wire       latchOn  = mask_q[`MSK_LATCH_BIT];

  // Pin input synchronisers
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {sclS1_q, sclS2_q, sclS3_q} <= 3'h7;
      {sdaS1_q, sdaS2_q, sdaS3_q} <= 3'h7;
    end else begin
      {sclS1_q, sclS2_q, sclS3_q} <= {sclIn, sclS1_q, sclS2_q};
      {sdaS1_q, sdaS2_q, sdaS3_q} <= {sdaIn, sdaS1_q, sdaS2_q};
    end
  end

  // Read multiplexer by pointer
  always @* begin
    case (ptr_q)
      `PTR_CONFIGURATION:      rdWord = cfgView;
      `PTR_CURRENT_RESULT:     rdWord = current_q;
      `PTR_BUS_VOLTAGE_RESULT: rdWord = voltage_q;
      `PTR_POWER_RESULT:       rdWord = power_q;
      `PTR_ALERT_MASK_ENABLE:  rdWord = {mask_q[15:5], funcFlag_q, readyFlag_q,
                                         mask_q[2:0]};
      `PTR_ALERT_LIMIT:        rdWord = limit_q;
      `PTR_MAKER_IDENTITY:     rdWord = MAKER_ID;
      `PTR_DIE_IDENTITY:       rdWord = DIE_ID;
      default:                 rdWord = 16'h0000;
    endcase
    if (isAra_q) begin
      txByte = {SLAVE_ADDR, 1'b0};
    end else if (txHi_q) begin
      txByte = rdWord[15:8];
    end else begin
      txByte = rdWord[7:0];
    end
  end

  // Serial protocol engine
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q   <= ST_IDLE;
      bitCnt_q  <= 4'h0;
      shift_q   <= 8'h00;
      ackOn_q   <= 1'b0;
      isRead_q  <= 1'b0;
      isAra_q   <= 1'b0;
      txHi_q    <= 1'b1;
      byteIdx_q <= 2'h0;
      ptr_q     <= 8'h00;
      msb_q     <= 8'h00;
      sdaOe_q   <= 1'b0;
      sdaOut_q  <= 1'b0;
      wrStb_q   <= 1'b0;
      wrData_q  <= 16'h0000;
      maskRd_q  <= 1'b0;
      araWin_q  <= 1'b0;
      halt_q    <= 1'b0;
      restart_q <= 1'b1;
    end else begin
      wrStb_q   <= 1'b0;
      maskRd_q  <= 1'b0;
      araWin_q  <= 1'b0;
      restart_q <= swRst_q;
      // Restart once the written configuration has landed in cfg_q
      if (wrStb_q && halt_q) begin
        halt_q    <= 1'b0;
        restart_q <= 1'b1;
      end
      if (busStart || busStop) begin
        state_q  <= busStart ? ST_ADDR : ST_IDLE;
        bitCnt_q <= 4'h0;
        sdaOe_q  <= 1'b0;
        if (halt_q) begin
          halt_q    <= 1'b0;
          restart_q <= 1'b1;
        end
      end else begin
        case (state_q)
          ST_ADDR, ST_RX: begin
            if (sclRise) begin
              shift_q  <= rxByte;
              bitCnt_q <= bitCnt_q + 4'h1;
              if (bitCnt_q == 4'h7) begin
                state_q <= ST_ACK;
                ackOn_q <= 1'b0;
                if (state_q == ST_ADDR) begin
                  isRead_q  <= rxByte[0];
                  byteIdx_q <= 2'h0;
                  txHi_q    <= 1'b1;
                  isAra_q   <= 1'b0;
                  if (rxByte[7:1] == SLAVE_ADDR) begin
                    isAra_q <= 1'b0;
                  end else if (rxByte == {`ALERT_RESPONSE_ADDR, 1'b1} && latchOn
                               && funcFlag_q && !released_q) begin
                    isAra_q <= 1'b1;
                  end else begin
                    state_q <= ST_IDLE;
                  end
                end else begin
                  if (byteIdx_q != 2'h3) begin
                    byteIdx_q <= byteIdx_q + 2'h1;
                  end
                  case (byteIdx_q)
                    2'h0: ptr_q <= rxByte;
                    2'h1: begin
                      msb_q  <= rxByte;
                      halt_q <= (ptr_q == `PTR_CONFIGURATION);
                    end
                    2'h2: begin
                      wrStb_q  <= 1'b1;
                      wrData_q <= {msb_q, rxByte};
                    end
                    default: ;
                  endcase
                end
              end
            end
          end
          ST_ACK: begin
            if (sclFall) begin
              ackOn_q <= ~ackOn_q;
              if (!ackOn_q) begin
                sdaOe_q <= 1'b1;
              end else if (isRead_q) begin
                state_q  <= ST_TX;
                bitCnt_q <= 4'h0;
                shift_q  <= txByte;
                sdaOe_q  <= ~txByte[7];
                txHi_q   <= ~txHi_q;
                maskRd_q <= !isAra_q && !txHi_q && ptr_q == `PTR_ALERT_MASK_ENABLE;
              end else begin
                state_q  <= ST_RX;
                bitCnt_q <= 4'h0;
                sdaOe_q  <= 1'b0;
              end
            end
          end
          ST_TX: begin
            if (sclRise) begin
              bitCnt_q <= bitCnt_q + 4'h1;
              if (isAra_q && !sdaOe_q && !sdaS2_q) begin
                state_q <= ST_IDLE;
              end
            end else if (sclFall) begin
              if (bitCnt_q == 4'h8) begin
                sdaOe_q  <= 1'b0;
                state_q  <= ST_MACK;
                araWin_q <= isAra_q;
              end else begin
                shift_q <= {shift_q[6:0], 1'b0};
                sdaOe_q <= ~shift_q[6];
              end
            end
          end
          ST_MACK: begin
            if (sclRise) begin
              state_q <= sdaS2_q ? ST_IDLE : ST_ACK;
              ackOn_q <= 1'b1;
            end
          end
          default: begin
            sdaOe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // Register file, flags and soft reset
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_q       <= CFG_RESET[11:0];
      mask_q      <= `RST_ALERT_MASK_ENABLE;
      limit_q     <= `RST_ALERT_LIMIT;
      current_q   <= `RST_RESULT;
      voltage_q   <= `RST_RESULT;
      power_q     <= `RST_RESULT;
      funcFlag_q  <= 1'b0;
      readyFlag_q <= 1'b0;
      released_q  <= 1'b0;
      swRst_q     <= 1'b0;
      alertOe_q   <= 1'b0;
      alertOut_q  <= 1'b0;
    end else begin
      swRst_q <= 1'b0;
      if (swRst_q) begin
        cfg_q       <= CFG_RESET[11:0];
        mask_q      <= `RST_ALERT_MASK_ENABLE;
        limit_q     <= `RST_ALERT_LIMIT;
        current_q   <= `RST_RESULT;
        voltage_q   <= `RST_RESULT;
        power_q     <= `RST_RESULT;
        funcFlag_q  <= 1'b0;
        readyFlag_q <= 1'b0;
        released_q  <= 1'b0;
        alertOe_q   <= 1'b0;
      end else begin
        if (wrStb_q) begin
          case (ptr_q)
            `PTR_CONFIGURATION: begin
              cfg_q   <= wrData_q[11:0];
              swRst_q <= wrData_q[`CFG_SW_RESET_BIT];
            end
            `PTR_ALERT_MASK_ENABLE: mask_q <= wrData_q & `MSK_RW_MASK;
            `PTR_ALERT_LIMIT:       limit_q <= wrData_q;
            default: ;
          endcase
        end
        if (convDone) begin
          current_q <= currentIn;
          voltage_q <= {1'b0, voltageIn[14:0]};
          power_q   <= powerIn;
        end
        // Hardware set wins over the read clear
        readyFlag_q <= convDone | (readyFlag_q & ~maskRd_q);
        if (latchOn) begin
          funcFlag_q <= alertCond | (funcFlag_q & ~maskRd_q);
        end else begin
          funcFlag_q <= alertCond;
        end
        released_q <= funcFlag_q & (released_q | araWin_q);
        alertOe_q  <= funcFlag_q & ~released_q & ~araWin_q;
      end
    end
  end

  // Conversion timebase
  conv_sequencer u_conv (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .halt        (halt_q),
    .restart     (restart_q),
    .avgSel      (cfg_q[`CFG_AVG_HI:`CFG_AVG_LO]),
    .voltTimeSel (cfg_q[`CFG_VCT_HI:`CFG_VCT_LO]),
    .currTimeSel (cfg_q[`CFG_ICT_HI:`CFG_ICT_LO]),
    .modeSel     (cfg_q[`CFG_MODE_HI:`CFG_MODE_LO]),
    .convDone_q  (convDone)
  );

endmodule // monitor_register_bank

// file: test/monitor_register_bank_props.sv
// Port-level assertions for the monitor register bank
`timescale 1ns/100ps
module monitor_register_bank_props (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Serial and alert pins
  input wire sclIn,
  input wire sdaOut_q,
  input wire sdaOe_q,
  input wire alertOut_q,
  input wire alertOe_q,
  // Comparator result
  input wire alertCond
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Pins are open drain, data only ever pulled low
  sda_open_drain_a: assert property (!sdaOut_q)
    else $error("data pin output value high");
  alert_open_drain_a: assert property (!alertOut_q)
    else $error("alert pin output value high");
  // Released pins right after reset
  reset_idle_a: assert property ($fell(sys_rst) |-> !sdaOe_q && !alertOe_q)
    else $error("pin driven after reset release");
  // Data changes only in the clock low phase
  sda_take_low_a: assert property ($rose(sdaOe_q) |-> !sclIn && !$past(sclIn))
    else $error("data pulled while clock high");
  sda_free_low_a: assert property ($fell(sdaOe_q) |-> !sclIn)
    else $error("data released while clock high");
  sda_steady_a: assert property (sclIn [*6] |-> $stable(sdaOe_q))
    else $error("data enable moved in clock high phase");
  // Alert rises only from a comparator event
  alert_cause_a: assert property ($rose(alertOe_q) |->
    $past(alertCond) || $past(alertCond, 2) || $past(alertCond, 3))
    else $error("alert asserted without cause");
  // No bus activity and condition held: alert must not drop
  alert_hold_a: assert property ((sclIn && alertCond) [*8] |=> !$fell(alertOe_q))
    else $error("alert dropped without bus service");

  // Main scenarios
  cover property ($rose(alertOe_q));
  cover property ($fell(alertOe_q));
  cover property ($rose(sdaOe_q) ##[1:20] $fell(sdaOe_q));
endmodule // monitor_register_bank_props

bind monitor_register_bank monitor_register_bank_props monitor_register_bank_props_i (
  .clk        (clk),
  .sys_rst    (sys_rst),
  .sclIn      (sclIn),
  .sdaOut_q   (sdaOut_q),
  .sdaOe_q    (sdaOe_q),
  .alertOut_q (alertOut_q),
  .alertOe_q  (alertOe_q),
  .alertCond  (alertCond)
);

// file: test/smbus_host_model.sv
// Host controller model for the serial bus and the shared alert line
`timescale 1ns/100ps
module smbus_host_model #(
  parameter [6:0] DEV_ADDR = 7'h40
) (
  // Device pin enables
  input  wire devSdaOe,
  input  wire devAlertOe,
  // Resolved lines
  output reg  sclLine,
  output wire sdaLine,
  output wire alertLine
);
  reg       hostPull;
  reg       rivalPull;
  reg [8:0] rx;

  // Open-drain lines with pull-ups; clock idles high outside frames
  assign sdaLine   = !(devSdaOe || hostPull || rivalPull);
  assign alertLine = !devAlertOe;
  initial begin
    sclLine = 1'b1;
    hostPull = 1'b0;
    rivalPull = 1'b0;
  end

  // Start, or repeated start from a low clock
  task start_cond;
    begin
      hostPull = 1'b0;
      #31.2 sclLine = 1'b1;
      #31.3 hostPull = 1'b1;
      #31.2 sclLine = 1'b0;
      #31.3;
    end
  endtask

  task stop_cond;
    begin
      hostPull = 1'b1;
      #31.2 sclLine = 1'b1;
      #31.3 hostPull = 1'b0;
      #62.5;
    end
  endtask

  // Nine clocks; host and rival bits released where set, line sampled mid high
  task xfer(input [8:0] tx, input [8:0] rv);
    integer i;
    begin
      for (i = 8; i >= 0; i = i - 1) begin
        hostPull = !tx[i];
        rivalPull = !rv[i];
        #31.3 sclLine = 1'b1;
        #31.2 rx[i] = sdaLine;
        #31.3 sclLine = 1'b0;
        #31.2;
      end
      rivalPull = 1'b0;
    end
  endtask

  // Address, pointer, MSB, LSB
  task write_word(input [7:0] ptr, input [15:0] val);
    begin
      start_cond;
      xfer({DEV_ADDR, 2'b01}, 9'h1FF);
      xfer({ptr, 1'b1}, 9'h1FF);
      xfer({val[15:8], 1'b1}, 9'h1FF);
      xfer({val[7:0], 1'b1}, 9'h1FF);
      stop_cond;
    end
  endtask

  // Pointer set, repeated start, two bytes, refusal after the second
  task read_word(input [7:0] ptr, output [15:0] val);
    begin
      start_cond;
      xfer({DEV_ADDR, 2'b01}, 9'h1FF);
      xfer({ptr, 1'b1}, 9'h1FF);
      start_cond;
      xfer({DEV_ADDR, 2'b11}, 9'h1FF);
      xfer(9'h1FE, 9'h1FF);
      val[15:8] = rx[8:1];
      xfer(9'h1FF, 9'h1FF);
      val[7:0] = rx[8:1];
      stop_cond;
    end
  endtask

  // Alert poll; a rival responder (8'hFF for none) may answer at once
  task alert_poll(input [7:0] rival, output ack, output [7:0] who);
    begin
      start_cond;
      xfer({7'h0C, 2'b11}, {8'hFF, rival == 8'hFF});
      ack = !rx[0];
      who = 8'hFF;
      if (ack) begin
        xfer(9'h1FF, {rival, 1'b1});
        who = rx[8:1];
      end
      stop_cond;
    end
  endtask
endmodule // smbus_host_model

// file: test/monitor_register_bank_tb.sv
// Self-checking bench for the monitor register bank
`timescale 1ns/100ps
module monitor_register_bank_tb;
  localparam [15:0] MAKER_VAL = 16'h0F0F; // Arbitrary value
  localparam [15:0] DIE_VAL   = 16'h3C3C; // Arbitrary value
  reg         clk;
  reg         sys_rst;
  reg  [15:0] currentIn;
  reg  [15:0] voltageIn;
  reg  [15:0] powerIn;
  reg         alertCond;
  wire        sclLine;
  wire        sdaLine;
  wire        alertLine;
  wire        sdaOut;
  wire        sdaOe;
  wire        alertOut;
  wire        alertOe;
  integer     failCount;
  integer     cmpCount;
  reg  [15:0] rd;
  reg         ack;
  reg  [7:0]  who;

  monitor_register_bank #(.SLAVE_ADDR(7'h40), .MAKER_ID(MAKER_VAL), .DIE_ID(DIE_VAL))
  monitor_register_bank_i (
    .clk(clk), .sys_rst(sys_rst), .sclIn(sclLine), .sdaIn(sdaLine),
    .sdaOut_q(sdaOut), .sdaOe_q(sdaOe), .alertOut_q(alertOut), .alertOe_q(alertOe),
    .currentIn(currentIn), .voltageIn(voltageIn), .powerIn(powerIn), .alertCond(alertCond));
  smbus_host_model smbus_host_model_i (
    .devSdaOe(sdaOe), .devAlertOe(alertOe), .sclLine(sclLine), .sdaLine(sdaLine),
    .alertLine(alertLine));

  // 125 MHz clock
  always #4 clk = ~clk;

  task check(input [15:0] seen, input [15:0] exp);
    begin
      cmpCount = cmpCount + 1;
      if (seen !== exp) begin
        failCount = failCount + 1;
        $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
    end
  endtask

  task stopTest;
    begin
      if (failCount == 0 && cmpCount > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask

  task wr(input [7:0] p, input [15:0] v);
    smbus_host_model_i.write_word(p, v);
  endtask

  // Read one register and compare under a mask
  task expect_reg(input [7:0] p, input [15:0] m, input [15:0] exp);
    begin
      smbus_host_model_i.read_word(p, rd);
      check(rd & m, exp);
    end
  endtask

  task t_defaults;
    begin
      expect_reg(8'h00, 16'hFFFF, 16'h6127);
      expect_reg(8'h01, 16'hFFFF, 16'h0000);
      expect_reg(8'h02, 16'hFFFF, 16'h0000);
      expect_reg(8'h03, 16'hFFFF, 16'h0000);
      expect_reg(8'h06, 16'hFFFF, 16'h0000);
      expect_reg(8'h07, 16'hFFFF, 16'h0000);
      expect_reg(8'hFE, 16'hFFFF, MAKER_VAL);
      expect_reg(8'hFF, 16'hFFFF, DIE_VAL);
    end
  endtask

  // Writes to fixed places, fixed config bits, writable fields
  task t_access;
    integer i;
    begin
      for (i = 1; i < 6; i = i + 1)
        wr((i < 4) ? i[7:0] : 8'hFA + i[7:0], 16'hFFFF);
      wr(8'h00, 16'h0E24);
      expect_reg(8'h00, 16'hFFFF, 16'h6E24);
      expect_reg(8'h00, 16'hFFFF, 16'h6E24);
      wr(8'h07, 16'hA5C3);
      expect_reg(8'h07, 16'hFFFF, 16'hA5C3);
      wr(8'h06, 16'hFFFE);
      expect_reg(8'h06, 16'hFFE7, 16'hFC02);
      expect_reg(8'h01, 16'hFFFF, 16'h0000);
      expect_reg(8'hFE, 16'hFFFF, MAKER_VAL);
    end
  endtask

  // Shortest times, triggered both channels: one sequence, then idle
  task t_convert;
    integer n;
    time t0;
    begin
      wr(8'h00, 16'h0003);
      t0 = $time;
      rd = 16'h0000;
      for (n = 0; n < 80 && rd[3] !== 1'b1; n = n + 1)
        smbus_host_model_i.read_word(8'h06, rd);
      if (rd[3] !== 1'b1) begin
        failCount = failCount + 1;
        stopTest;
      end
      check({15'h0000, ($time - t0) >= 270000}, 16'h0001);
      check({15'h0000, ($time - t0) < 300000}, 16'h0001);
      expect_reg(8'h01, 16'hFFFF, 16'h8123);
      expect_reg(8'h02, 16'hFFFF, 16'h4456);
      expect_reg(8'h03, 16'hFFFF, 16'h789A);
      expect_reg(8'h06, 16'h0008, 16'h0000);
    end
  endtask

  task t_alert;
    begin
      @(negedge clk);
      alertCond = 1'b1;
      repeat (8) @(negedge clk);
      check({15'h0000, alertLine}, 16'h0000);
      smbus_host_model_i.alert_poll(8'hFF, ack, who);
      check({15'h0000, ack}, 16'h0000);
      @(negedge clk);
      alertCond = 1'b0;
      wr(8'h06, 16'h0001);
      @(negedge clk);
      alertCond = 1'b1;
      repeat (2) @(negedge clk);
      alertCond = 1'b0;
      repeat (8) @(negedge clk);
      check({15'h0000, alertLine}, 16'h0000);
      smbus_host_model_i.alert_poll(8'h20, ack, who);
      check({7'h00, ack, who}, 16'h0120);
      check({15'h0000, alertLine}, 16'h0000);
      smbus_host_model_i.alert_poll(8'hFF, ack, who);
      check({7'h00, ack, who}, 16'h0180);
      check({15'h0000, alertLine}, 16'h0001);
      expect_reg(8'h06, 16'h0011, 16'h0011);
      expect_reg(8'h06, 16'h0010, 16'h0000);
      check({15'h0000, alertLine}, 16'h0001);
    end
  endtask

  task t_soft_reset;
    begin
      wr(8'h07, 16'h1234);
      wr(8'h00, 16'h8003);
      expect_reg(8'h00, 16'hFFFF, 16'h6127);
      expect_reg(8'h07, 16'hFFFF, 16'h0000);
      expect_reg(8'h01, 16'hFFFF, 16'h0000);
      expect_reg(8'h06, 16'hFFFF, 16'h0000);
    end
  endtask

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    currentIn = 16'h8123;
    voltageIn = 16'hC456;
    powerIn = 16'h789A;
    alertCond = 1'b0;
    failCount = 0;
    cmpCount = 0;
    repeat (16) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    t_defaults;
    t_access;
    t_convert;
    t_alert;
    t_soft_reset;
    stopTest;
  end
endmodule // monitor_register_bank_tb
